// *** hw/tap_defines.vh ***
// Constants for the test access port: instruction codes, register lengths and controller states.
`ifndef TAP_DEFINES_VH
`define TAP_DEFINES_VH

`define IR_LEN            8
`define IDCODE_LEN        32
`define SIG_LEN           32
`define ADDR_LEN          169
`define DATA_LEN          243

`define OP_EXTEST         8'h00
`define OP_ADDR_SCAN      8'h01
`define OP_DATA_SCAN      8'h02
`define OP_BULK_ERASE     8'h03
`define OP_PROG_ARRAY     8'h07
`define OP_PROG_SECURITY  8'h09
`define OP_VERIFY_ARRAY   8'h0A
`define OP_IN_CLEAR       8'h12
`define OP_IN_SET         8'h13
`define OP_DISCHARGE      8'h14
`define OP_PROG_ENABLE    8'h15
`define OP_IDCODE         8'h16
`define OP_SIG_READ       8'h17
`define OP_OUTPUTS_OFF    8'h18
`define OP_SIG_PROGRAM    8'h1A
`define OP_SAMPLE         8'h1C
`define OP_PROG_DISABLE   8'h1E
`define OP_ADDR_INIT      8'h21
`define OP_DEV_RESET      8'h22
`define OP_DONE_ERASE     8'h24
`define OP_PROG_INCR      8'h27
`define OP_CFG_VERIFY     8'h28
`define OP_CFG_ERASE      8'h29
`define OP_VERIFY_INCR    8'h2A
`define OP_CFG_ADDR       8'h2B
`define OP_CFG_DATA       8'h2D
`define OP_CFG_PROGRAM    8'h2E
`define OP_DONE_PROGRAM   8'h2F
`define OP_BYPASS         8'hFF

`define ST_RESET          4'h0
`define ST_IDLE           4'h1
`define ST_SEL_DR         4'h2
`define ST_CAP_DR         4'h3
`define ST_SHIFT_DR       4'h4
`define ST_EX1_DR         4'h5
`define ST_PAUSE_DR       4'h6
`define ST_EX2_DR         4'h7
`define ST_UPD_DR         4'h8
`define ST_SEL_IR         4'h9
`define ST_CAP_IR         4'hA
`define ST_SHIFT_IR       4'hB
`define ST_EX1_IR         4'hC
`define ST_PAUSE_IR       4'hD
`define ST_EX2_IR         4'hE
`define ST_UPD_IR         4'hF

`define IDLE_ACT_EDGE     2'h2

`endif

// *** hw/tap_ctrl.v ***
// Test access port controller with instruction decode and the serial data paths.
`timescale 1ns/100ps
//
// Summary of operation
// - Sample inputs on rising, drive output on falling.
// - Sixteen-state controller steered by mode select.
// - Mode select high reaches reset within five.
// - Power-on starts in test-logic reset.
// - Reset leads to idle; idle launches program, erase, verify.
// - Capture-data loads identity, signature or clears bypass; address/data hold.
// - Capture-instruction loads the identification code.
// - Capture goes to shift or exit-one, then update/pause.
// - Pause resumes via exit-two or updates.
// - Program, erase, verify start at second idle edge.
// - Other instructions take effect at update.
// - All-ones code selects one-bit bypass.
// - Sample/preload code selects bypass.
// - All-zeros code selects bypass.
// - Identification code selects 32-bit identity register.
// - Identity readable after reset without instruction.
// - Force-outputs-off disables open-drain, pulls drivers low.
// - Configuration erase spares the logic array.
// - Address scan selects 169-bit register.
// - Data scan selects 243-bit register.
// - Signature read loads and shifts 32 bits.
// - Two codes set or clear logic input one.
// - Instruction register is eight bits.
// - Program/erase act at second idle edge.
// - Program/erase need programming mode first.
// - Reset state cancels programming mode.
`include "tap_defines.vh"

module tap_ctrl #(
   parameter [31:0] IDCODE_VALUE = 32'h0000_0001  // Arbitrary identity value.
) (
   input  wire                  i_clk,            // System clock, 10 MHz.
   input  wire                  i_sys_rst,        // Asynchronous reset, active high.
   input  wire                  i_tck,            // Test clock pin.
   input  wire                  i_tms,            // Mode select pin.
   input  wire                  i_tdi,            // Serial data in pin.
   input  wire [31:0]           i_sig_nv,         // User signature held in non-volatile memory.
   output reg                   o_tdo,            // Serial data out.
   output reg                   o_tdo_oe,         // Output enable for serial data out.
   output reg                   o_outputs_off,    // Open-drains off, drivers pulled low.
   output reg                   o_logic_input_one,// Scan-controlled logic input bit.
   output reg                   o_prog_mode,      // Programming mode active.
   output reg  [7:0]            o_nv_op,          // Non-volatile operation code.
   output reg                   o_nv_strobe       // One-cycle start of that operation.
);

   //---------------------------------------------------------------
   // Pin synchronisers and test-clock edge detection
   //---------------------------------------------------------------
   reg [1:0] tck_s_r;   // Test clock synchroniser.
   reg [1:0] tms_s_r;   // Mode select synchroniser.
   reg [1:0] tdi_s_r;   // Data in synchroniser.
   reg       tck_d_r;   // Previous synchronised test clock.
   wire      rise = tck_s_r[1] & ~tck_d_r;  // Rising test-clock edge.
   wire      fall = ~tck_s_r[1] & tck_d_r;  // Falling test-clock edge.

   // Two flip-flops on every pin before any logic reads it.
   always @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         tck_s_r <= 2'h0;
         tms_s_r <= 2'h3;
         tdi_s_r <= 2'h0;
         tck_d_r <= 1'b0;
      end else begin
         tck_s_r <= {tck_s_r[0], i_tck};
         tms_s_r <= {tms_s_r[0], i_tms};
         tdi_s_r <= {tdi_s_r[0], i_tdi};
         tck_d_r <= tck_s_r[1];
      end
   end

   wire tms = tms_s_r[1];  // Synchronised mode select.
   wire tdi = tdi_s_r[1];  // Synchronised data in.

   //---------------------------------------------------------------
   // Controller state machine
   //---------------------------------------------------------------
   reg [3:0] state_r;   // Current controller state.
   reg [3:0] state_nxt; // Next controller state.

   // Standard state graph; high mode select always heads to reset.
   always @* begin
      case (state_r)
         `ST_RESET:    state_nxt = tms ? `ST_RESET   : `ST_IDLE;
         `ST_IDLE:     state_nxt = tms ? `ST_SEL_DR  : `ST_IDLE;
         `ST_SEL_DR:   state_nxt = tms ? `ST_SEL_IR  : `ST_CAP_DR;
         `ST_CAP_DR:   state_nxt = tms ? `ST_EX1_DR  : `ST_SHIFT_DR;
         `ST_SHIFT_DR: state_nxt = tms ? `ST_EX1_DR  : `ST_SHIFT_DR;
         `ST_EX1_DR:   state_nxt = tms ? `ST_UPD_DR  : `ST_PAUSE_DR;
         `ST_PAUSE_DR: state_nxt = tms ? `ST_EX2_DR  : `ST_PAUSE_DR;
         `ST_EX2_DR:   state_nxt = tms ? `ST_UPD_DR  : `ST_SHIFT_DR;
         `ST_UPD_DR:   state_nxt = tms ? `ST_SEL_DR  : `ST_IDLE;
         `ST_SEL_IR:   state_nxt = tms ? `ST_RESET   : `ST_CAP_IR;
         `ST_CAP_IR:   state_nxt = tms ? `ST_EX1_IR  : `ST_SHIFT_IR;
         `ST_SHIFT_IR: state_nxt = tms ? `ST_EX1_IR  : `ST_SHIFT_IR;
         `ST_EX1_IR:   state_nxt = tms ? `ST_UPD_IR  : `ST_PAUSE_IR;
         `ST_PAUSE_IR: state_nxt = tms ? `ST_EX2_IR  : `ST_PAUSE_IR;
         `ST_EX2_IR:   state_nxt = tms ? `ST_UPD_IR  : `ST_SHIFT_IR;
         `ST_UPD_IR:   state_nxt = tms ? `ST_SEL_DR  : `ST_IDLE;
         default:      state_nxt = `ST_RESET;
      endcase
   end

   // State advances only on a rising test-clock edge.
   always @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state_r <= `ST_RESET;
      end else if (rise) begin
         state_r <= state_nxt;
      end
   end

   //---------------------------------------------------------------
   // Instruction register and data registers
   //---------------------------------------------------------------
   reg  [7:0]          ir_shift_r; // Instruction shift stage.
   reg  [7:0]          ir_r;       // Active instruction.
   reg                 byp_r;      // One-bit bypass register.
   reg  [31:0]         id_r;       // Identity shift register.
   reg  [31:0]         sig_r;      // Signature shift register.
   reg  [`ADDR_LEN-1:0] addr_r;    // Logic array address register.
   reg  [`DATA_LEN-1:0] data_r;    // Logic array data register.
   // Path codes: 0 bypass, 1 identity, 2 signature, 3 address, 4 data.
   reg  [2:0]          path;       // Path selector decoded from the instruction.

   // Decode the active instruction into a data path.
   always @* begin
      case (ir_r)
         `OP_IDCODE:    path = 3'h1;
         `OP_SIG_READ:  path = 3'h2;
         `OP_ADDR_SCAN: path = 3'h3;
         `OP_DATA_SCAN: path = 3'h4;
         `OP_BYPASS:    path = 3'h0;
         `OP_SAMPLE:    path = 3'h0;
         `OP_EXTEST:    path = 3'h0;
         default:       path = 3'h0;
      endcase
   end

   // Capture, shift and update of the instruction and data paths.
   always @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ir_shift_r <= 8'h00;
         ir_r       <= `OP_IDCODE;
         byp_r      <= 1'b0;
         id_r       <= 32'h0000_0000;
         sig_r      <= 32'h0000_0000;
         addr_r     <= {`ADDR_LEN{1'b0}};
         data_r     <= {`DATA_LEN{1'b0}};
      end else if (rise) begin
         case (state_r)
            `ST_RESET: begin
               ir_r <= `OP_IDCODE;
            end
            `ST_CAP_IR: begin
               ir_shift_r <= `OP_IDCODE;
            end
            `ST_SHIFT_IR: begin
               ir_shift_r <= {tdi, ir_shift_r[7:1]};
            end
            `ST_UPD_IR: begin
               ir_r <= ir_shift_r;
            end
            `ST_CAP_DR: begin
               // Parallel load of the identity or signature path; bypass clears, address and data hold.
               byp_r <= 1'b0;
               if (path == 3'h1) begin
                  id_r <= IDCODE_VALUE;
               end
               if (path == 3'h2) begin
                  sig_r <= i_sig_nv;
               end
            end
            `ST_SHIFT_DR: begin
               case (path)
                  3'h1:    id_r   <= {tdi, id_r[31:1]};
                  3'h2:    sig_r  <= {tdi, sig_r[31:1]};
                  3'h3:    addr_r <= {tdi, addr_r[`ADDR_LEN-1:1]};
                  3'h4:    data_r <= {tdi, data_r[`DATA_LEN-1:1]};
                  default: byp_r  <= tdi;
               endcase
            end
            default: begin
               // Pause and other states hold every register.
            end
         endcase
      end
   end

   //---------------------------------------------------------------
   // Serial output on the falling edge
   //---------------------------------------------------------------
   reg tdo_bit; // Bit that leads the selected path.

   // Pick the bit presented at the serial output.
   always @* begin
      if (state_r == `ST_SHIFT_IR) begin
         tdo_bit = ir_shift_r[0];
      end else begin
         case (path)
            3'h1:    tdo_bit = id_r[0];
            3'h2:    tdo_bit = sig_r[0];
            3'h3:    tdo_bit = addr_r[0];
            3'h4:    tdo_bit = data_r[0];
            default: tdo_bit = byp_r;
         endcase
      end
   end

   // Output and its enable change only on the falling edge.
   always @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_tdo    <= 1'b0;
         o_tdo_oe <= 1'b0;
      end else if (fall) begin
         o_tdo    <= tdo_bit;
         o_tdo_oe <= (state_r == `ST_SHIFT_DR) || (state_r == `ST_SHIFT_IR);
      end
   end

   //---------------------------------------------------------------
   // Instruction effects: update-time and idle-time actions
   //---------------------------------------------------------------
   reg [1:0] idle_cnt_r; // Rising edges counted while in idle.
   reg       nv_kind;    // Instruction runs in idle rather than at update.
   reg       needs_prog; // Instruction needs programming mode.

   // Classify instructions that act in idle.
   always @* begin
      case (ir_r)
         `OP_BULK_ERASE, `OP_PROG_ARRAY, `OP_PROG_SECURITY, `OP_CFG_ERASE, `OP_CFG_PROGRAM,
         `OP_SIG_PROGRAM, `OP_PROG_INCR: begin
            nv_kind    = 1'b1;
            needs_prog = 1'b1;
         end
         `OP_VERIFY_ARRAY, `OP_CFG_VERIFY, `OP_VERIFY_INCR, `OP_DISCHARGE: begin
            nv_kind    = 1'b1;
            needs_prog = 1'b0;
         end
         default: begin
            nv_kind    = 1'b0;
            needs_prog = 1'b0;
         end
      endcase
   end

   // Update-state effects and the idle-time launch of array operations.
   always @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_outputs_off     <= 1'b0;
         o_logic_input_one <= 1'b0;
         o_prog_mode       <= 1'b0;
         o_nv_op           <= 8'h00;
         o_nv_strobe       <= 1'b0;
         idle_cnt_r        <= 2'h0;
      end else begin
         o_nv_strobe <= 1'b0;
         if (rise) begin
            // Clearing on the edge that enters reset, not one edge later, keeps the
            // five-edge escape with mode select high valid for programming mode too.
            if (state_nxt == `ST_RESET) begin
               o_prog_mode   <= 1'b0;
               o_outputs_off <= 1'b0;
            end
            if (state_r == `ST_UPD_IR) begin
               // Update-time instructions act here.
               case (ir_shift_r)
                  `OP_PROG_ENABLE:  o_prog_mode <= 1'b1;
                  `OP_PROG_DISABLE: o_prog_mode <= 1'b0;
                  `OP_IN_SET:       o_logic_input_one <= 1'b1;
                  `OP_IN_CLEAR:     o_logic_input_one <= 1'b0;
                  default: begin
                  end
               endcase
               // Forcing outputs off also accompanies array access codes.
               o_outputs_off <= (ir_shift_r != `OP_IDCODE) && (ir_shift_r != `OP_BYPASS) &&
                                (ir_shift_r != `OP_SAMPLE) && (ir_shift_r != `OP_EXTEST) &&
                                (ir_shift_r != `OP_IN_SET) && (ir_shift_r != `OP_IN_CLEAR) &&
                                (ir_shift_r != `OP_SIG_READ) && (ir_shift_r != `OP_PROG_DISABLE) &&
                                (ir_shift_r[7:6] == 2'h0);
            end
            // Count edges spent in idle; launch on the second.
            if (state_r == `ST_IDLE) begin
               if (idle_cnt_r != `IDLE_ACT_EDGE) begin
                  idle_cnt_r <= idle_cnt_r + 2'h1;
               end
               if ((idle_cnt_r == 2'h1) && nv_kind && (!needs_prog || o_prog_mode)) begin
                  o_nv_op     <= ir_r;
                  o_nv_strobe <= 1'b1;
               end
            end else begin
               idle_cnt_r <= 2'h0;
            end
         end
      end
   end

endmodule // tap_ctrl

// *** sim/jtag_master.sv ***
// Behavioural test-port master that clocks frames into the controller.
`timescale 1ns/100ps
module jtag_master (
   input  wire i_clk, // System clock.
   input  wire i_tdo, // Serial data from the device.
   output reg  o_tck, // Test clock, still between frames.
   output reg  o_tms, // Mode select.
   output reg  o_tdi  // Serial data to the device.
);
   initial begin
      o_tck = 1'b0;
      o_tms = 1'b1;
      o_tdi = 1'b0;
   end
   // One 800 ns period: 5 clocks low, 3 high; data out is taken just before the rise.
   task step(input logic tms_v, input logic tdi_v, output logic tdo_v);
      begin
         o_tms <= tms_v;
         o_tdi <= tdi_v;
         repeat (5) @(posedge i_clk);
         tdo_v = i_tdo;
         o_tck <= 1'b1;
         repeat (3) @(posedge i_clk);
         o_tck <= 1'b0;
      end
   endtask
   // A move outside shifting keeps the data line toggling, so no stale value is offered.
   task move(input logic tms_v);
      logic d;
      begin
         step(tms_v, ~o_tdi, d);
      end
   endtask
   // A full scan from idle back to idle, with an optional pause after bit p.
   task scan(input logic ir, input logic [255:0] din, input int n, input int p, output logic [255:0] dout);
      int i;
      logic b;
      begin
         dout = '0;
         move(1'b1);
         if (ir) move(1'b1);
         move(1'b0);
         move(1'b0);
         for (i = 0; i < n; i++) begin
            step((i == n - 1) || (i == p), din[i], b);
            dout[i] = b;
            if (i == p && i != n - 1) begin
               move(1'b0);
               move(1'b0);
               move(1'b1);
               move(1'b0);
            end
         end
         move(1'b1);
         move(1'b0);
      end
   endtask
   // Five rises with mode select high, then back to idle.
   task reset5;
      begin
         repeat (5) move(1'b1);
         move(1'b0);
      end
   endtask
endmodule // jtag_master

// *** sim/tap_ctrl_asserts.sv ***
// Concurrent checks on the ports of the test access port controller.
`timescale 1ns/100ps
module tap_ctrl_asserts (
   input wire       i_clk,
   input wire       i_sys_rst,
   input wire       i_tck,
   input wire       i_tms,
   input wire       o_tdo,
   input wire       o_tdo_oe,
   input wire       o_outputs_off,
   input wire       o_logic_input_one,
   input wire       o_prog_mode,
   input wire [7:0] o_nv_op,
   input wire       o_nv_strobe
);
   logic       tck_d;      // Test clock seen one cycle ago.
   logic [2:0] hi_cnt;     // Rises in a row with mode select high.
   logic [3:0] since_rise; // Cycles since the last test-clock rise.
   wire        rise = i_tck & ~tck_d;
   // Helper counters track the raw test clock.
   always @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         tck_d <= 1'b0;
         hi_cnt <= 3'h0;
         since_rise <= 4'hF;
      end else begin
         tck_d <= i_tck;
         if (rise) hi_cnt <= i_tms ? ((hi_cnt == 3'h7) ? hi_cnt : hi_cnt + 3'h1) : 3'h0;
         since_rise <= rise ? 4'h0 : ((since_rise == 4'hF) ? since_rise : since_rise + 4'h1);
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   property p_strobe_one;
      o_nv_strobe |=> !o_nv_strobe;
   endproperty
   property p_strobe_mode;
      o_nv_strobe && (o_nv_op inside {8'h03, 8'h07, 8'h09, 8'h1A, 8'h27, 8'h29, 8'h2E}) |-> o_prog_mode;
   endproperty
   property p_tdo_fall;
      $changed(o_tdo) |-> !i_tck;
   endproperty
   property p_oe_fall;
      $changed(o_tdo_oe) |-> !i_tck;
   endproperty
   property p_tms_reset;
      (hi_cnt == 3'h5) && $changed(hi_cnt) |-> ##[1:8] (!o_prog_mode && !o_outputs_off && !o_tdo_oe);
   endproperty
   property p_strobe_edge;
      o_nv_strobe |-> since_rise <= 4'h8;
   endproperty
   property p_upd_edge;
      $changed(o_logic_input_one) || $changed(o_prog_mode) |-> since_rise <= 4'h8;
   endproperty
   property p_off_edge;
      $rose(o_outputs_off) |-> since_rise <= 4'h8;
   endproperty
   a_strobe_one: assert property (p_strobe_one) else $error("strobe longer than one cycle");
   a_strobe_mode: assert property (p_strobe_mode) else $error("program launched outside mode");
   a_tdo_fall: assert property (p_tdo_fall) else $error("data out moved while clock high");
   a_oe_fall: assert property (p_oe_fall) else $error("enable moved while clock high");
   a_tms_reset: assert property (p_tms_reset) else $error("no reset after five high rises");
   a_strobe_edge: assert property (p_strobe_edge) else $error("strobe not tied to a rise");
   a_upd_edge: assert property (p_upd_edge) else $error("update effect not tied to a rise");
   a_off_edge: assert property (p_off_edge) else $error("outputs off not tied to a rise");
   c_strobe: cover property (o_nv_strobe);
   c_mode: cover property ($rose(o_prog_mode));
   c_in_one: cover property ($rose(o_logic_input_one));
endmodule // tap_ctrl_asserts
bind tap_ctrl tap_ctrl_asserts u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_tck(i_tck), .i_tms(i_tms),
   .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe), .o_outputs_off(o_outputs_off), .o_logic_input_one(o_logic_input_one),
   .o_prog_mode(o_prog_mode), .o_nv_op(o_nv_op), .o_nv_strobe(o_nv_strobe));

// *** sim/tb_top.sv ***
// Self-checking bench for the test access port controller.
`timescale 1ns/100ps
module tb_top;
   localparam [31:0] ID_VAL  = 32'h2468ACE1; // Arbitrary identity value.
   localparam [31:0] SIG_VAL = 32'hC3A51E96; // Arbitrary signature contents.
   logic         clk, rst, tck, tms, tdi, tdo, tdo_oe, outs_off, in_one, prog_mode, nv_strobe;
   logic [31:0]  sig_nv;
   logic [7:0]   nv_op, last_op;
   logic [255:0] dout;
   int           err_count = 0;
   int           n_compared = 0;
   int           n_strobe = 0;
   logic         seen_oe = 1'b0; // Output enable seen high during a shift.
   logic [7:0]   codes [8] = '{8'h00, 8'hFF, 8'h1C, 8'h5B, 8'h16, 8'h17, 8'h01, 8'h02};
   int           lens [8] = '{1, 1, 1, 1, 32, 32, 169, 243};
   initial clk = 1'b0;
   always #50 clk = ~clk;
   // Launches are counted so that their number and code can be judged.
   always @(posedge clk) begin
      if (nv_strobe === 1'b1) begin
         n_strobe <= n_strobe + 1;
         last_op <= nv_op;
      end
      if (tdo_oe === 1'b1) begin
         seen_oe <= 1'b1;
      end
   end
   tap_ctrl #(.IDCODE_VALUE(ID_VAL)) dut (.i_clk(clk), .i_sys_rst(rst), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
      .i_sig_nv(sig_nv), .o_tdo(tdo), .o_tdo_oe(tdo_oe), .o_outputs_off(outs_off), .o_logic_input_one(in_one),
      .o_prog_mode(prog_mode), .o_nv_op(nv_op), .o_nv_strobe(nv_strobe));
   jtag_master m (.i_clk(clk), .i_tdo(tdo), .o_tck(tck), .o_tms(tms), .o_tdi(tdi));
   task chk(input logic [255:0] seen, input logic [255:0] exp);
      begin
         n_compared++;
         if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen %0h expected %0h", $time, seen, exp);
         end
      end
   endtask
   task print_verdict;
      begin
         $display("Compared %0d, mismatches %0d", n_compared, err_count);
         if (err_count == 0 && n_compared > 0) $display("Finished cleanly");
         else $display("Finished with errors");
         $finish;
      end
   endtask
   // Loads an instruction and lets its effect settle.
   task load_ir(input logic [7:0] code);
      begin
         m.scan(1'b1, {248'h0, code}, 8, -1, dout);
         repeat (6) @(posedge clk);
      end
   endtask
   // Identity readable straight after reset; capture shows the identity code and an 8-bit delay.
   task t_after_reset;
      begin
         m.move(1'b0);
         m.scan(1'b0, 256'h1, 256, -1, dout);
         chk(dout[31:0], ID_VAL);
         chk(seen_oe, 1'b1);
         chk(dout >> 32, 256'h1);
         m.scan(1'b1, 256'h00FF, 16, -1, dout);
         chk(dout[7:0], 8'h16);
         chk(dout[15:8], 8'hFF);
      end
   endtask
   // Every listed path is measured by the delay of a single marker bit.
   task t_paths;
      int k;
      begin
         for (k = 0; k < 8; k++) begin
            load_ir(codes[k]);
            chk(outs_off, (codes[k] == 8'h01) || (codes[k] == 8'h02));
            chk(tdo_oe, 1'b0);
            m.scan(1'b0, 256'h1, 256, -1, dout);
            chk(dout >> lens[k], 256'h1);
            if (codes[k] == 8'h16) chk(dout[31:0], ID_VAL);
            if (codes[k] == 8'h17) chk(dout[31:0], SIG_VAL);
         end
      end
   endtask
   // Force-off, input bit and pauses in both scans.
   task t_controls;
      begin
         load_ir(8'h18);
         chk(outs_off, 1'b1);
         load_ir(8'h13);
         chk(in_one, 1'b1);
         chk(outs_off, 1'b0);
         load_ir(8'h12);
         chk(in_one, 1'b0);
         m.scan(1'b1, 256'h16, 8, 3, dout);
         m.scan(1'b0, 256'h1, 64, 10, dout);
         chk(dout[31:0], ID_VAL);
         chk(dout >> 32, 256'h1);
      end
   endtask
   // Program refused outside mode, erase launched on the second idle rise, reset cancels mode.
   task t_prog;
      int k;
      begin
         k = n_strobe;
         load_ir(8'h07);
         repeat (2) m.move(1'b0);
         repeat (6) @(posedge clk);
         chk(n_strobe, k);
         load_ir(8'h15);
         chk(prog_mode, 1'b1);
         load_ir(8'h29);
         chk(n_strobe, k);
         m.move(1'b0);
         repeat (6) @(posedge clk);
         chk(n_strobe, k);
         m.move(1'b0);
         repeat (6) @(posedge clk);
         chk(n_strobe, k + 1);
         chk(last_op, 8'h29);
         m.reset5;
         repeat (6) @(posedge clk);
         chk(prog_mode, 1'b0);
         chk(outs_off, 1'b0);
         m.scan(1'b0, 256'h1, 32, -1, dout);
         chk(dout[31:0], ID_VAL);
         // A verify code launches in idle without programming mode.
         load_ir(8'h0A);
         repeat (2) m.move(1'b0);
         repeat (6) @(posedge clk);
         chk(n_strobe, k + 2);
         chk(last_op, 8'h0A);
      end
   endtask
   initial begin
      rst = 1'b1;
      sig_nv = SIG_VAL;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      t_after_reset;
      t_paths;
      t_controls;
      t_prog;
      print_verdict;
   end
   // Watchdog sized well above the roughly 22000 cycles the tests take.
   initial begin
      #(60000 * 100);
      err_count++;
      $display("BAD t=%0t watchdog expired", $time);
      print_verdict;
   end
endmodule // tb_top
